// File: shared/sat_pkg.sv
// Constants, register map and types shared by the segment address translator
package sat_pkg;

   // Address widths
   localparam int SAT_PA_W   = 24;
   localparam int SAT_SEL_W  = 16;
   localparam int SAT_OFF_W  = 16;
   localparam int SAT_IDX_W  = 13;
   localparam int SAT_RA_W   = 20;
   localparam int SAT_APB_AW = 8;

   // Segment cache slots: four segment registers plus the local table register
   localparam int SAT_SLOTS = 5;
   localparam logic [2:0] SAT_SLOT_CODE  = 3'h0;
   localparam logic [2:0] SAT_SLOT_DATA  = 3'h1;
   localparam logic [2:0] SAT_SLOT_EXTRA = 3'h2;
   localparam logic [2:0] SAT_SLOT_STACK = 3'h3;
   localparam logic [2:0] SAT_SLOT_LTAB  = 3'h4;

   // Selector fields
   localparam int SAT_SEL_RPL_LSB = 0;
   localparam int SAT_SEL_TI_BIT  = 2;
   localparam int SAT_SEL_IDX_LSB = 3;
   localparam logic [3:0] SAT_REAL_SHIFT_PAD = 4'h0;   // selector times sixteen
   localparam logic [2:0] SAT_DESC_SHIFT_PAD = 3'h0;   // index times eight
   localparam logic [SAT_IDX_W-1:0] SAT_GTAB_MAX_IDX = 13'h00FF;

   // Descriptor layout as three 16-bit words
   localparam logic [SAT_PA_W-1:0] SAT_DESC_WORD_STEP = 24'h000002;
   localparam int SAT_ACC_DPL_LSB = 5;

   // Reset state and forced upper address nibble
   localparam logic [SAT_SEL_W-1:0] SAT_CODE_RESET_SEL  = 16'hF000;
   localparam logic [SAT_PA_W-1:0]  SAT_CODE_RESET_BASE = 24'hFF0000;
   localparam logic [SAT_OFF_W-1:0] SAT_RESET_LIMIT     = 16'hFFFF;
   localparam logic [7:0]           SAT_RESET_ACCESS    = 8'h93;
   localparam logic [3:0]           SAT_NIBBLE_HIGH     = 4'hF;
   localparam logic [3:0]           SAT_NIBBLE_LOW      = 4'h0;
   localparam logic [SAT_PA_W-1:0]  SAT_RESET_VECTOR    = 24'hFFFFF0;

   // Register byte offsets
   localparam logic [SAT_APB_AW-1:0] SAT_REG_CTRL   = 8'h00;
   localparam logic [SAT_APB_AW-1:0] SAT_REG_STATUS = 8'h04;
   localparam logic [SAT_APB_AW-1:0] SAT_REG_MASK   = 8'h08;
   localparam logic [SAT_APB_AW-1:0] SAT_REG_GBASE  = 8'h0C;
   localparam logic [SAT_APB_AW-1:0] SAT_REG_GLIMIT = 8'h10;
   localparam logic [SAT_APB_AW-1:0] SAT_REG_LSEL   = 8'h14;
   localparam logic [SAT_APB_AW-1:0] SAT_REG_LBASE  = 8'h18;
   localparam logic [SAT_APB_AW-1:0] SAT_REG_LLIM   = 8'h1C;
   localparam logic [SAT_APB_AW-1:0] SAT_REG_LASTPA = 8'h20;
   localparam logic [SAT_APB_AW-1:0] SAT_REG_STATE  = 8'h24;

   // Status event bits
   localparam int SAT_EV_W     = 4;
   localparam int SAT_EV_PRIV  = 0;
   localparam int SAT_EV_LIMIT = 1;
   localparam int SAT_EV_GIDX  = 2;
   localparam int SAT_EV_LOAD  = 3;

   // Descriptor loader states, Gray along the fetch path
   typedef enum logic [1:0] {
      SAT_LD_IDLE = 2'b00,
      SAT_LD_W0   = 2'b01,
      SAT_LD_W1   = 2'b11,
      SAT_LD_W2   = 2'b10
   } sat_ld_state_t;

endpackage

// File: verilog/sat_desc_loader.sv
// Three-word descriptor fetch from a descriptor table in memory
`timescale 1ns/1ps
`default_nettype none
module sat_desc_loader
   import sat_pkg::*;
(
   input  wire logic                         i_ref_clk,
   input  wire logic                         i_resetn,
   input  wire logic                         i_start,
   input  wire logic [sat_pkg::SAT_PA_W-1:0] i_desc_addr,
   input  wire logic                         i_mem_ack,
   input  wire logic [15:0]                  i_mem_rdata,
   output logic                              o_mem_rd,
   output logic [sat_pkg::SAT_PA_W-1:0]      o_mem_addr,
   output logic                              o_done,
   output logic [sat_pkg::SAT_OFF_W-1:0]     o_limit,
   output logic [sat_pkg::SAT_PA_W-1:0]      o_base,
   output logic [7:0]                        o_access
);
   import sat_pkg::*;

   sat_ld_state_t state;
   sat_ld_state_t next_state;
   wire           word_taken;

   // A word is taken only on the acknowledge edge
   assign word_taken = o_mem_rd & i_mem_ack;

   // Next state along limit, base low, base high plus access
   always_comb begin
      next_state = state;
      unique case (state)
         SAT_LD_IDLE: if (i_start) next_state = SAT_LD_W0;
         SAT_LD_W0:   if (word_taken) next_state = SAT_LD_W1;
         SAT_LD_W1:   if (word_taken) next_state = SAT_LD_W2;
         SAT_LD_W2:   if (word_taken) next_state = SAT_LD_IDLE;
      endcase
   end

   // Read strobe held until acknowledged; address steps one word each time
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state      <= SAT_LD_IDLE;
         o_mem_rd   <= 1'b0;
         o_mem_addr <= '0;
         o_done     <= 1'b0;
      end else begin
         state  <= next_state;
         o_done <= word_taken && (state == SAT_LD_W2);
         if (state == SAT_LD_IDLE && i_start) begin
            o_mem_rd   <= 1'b1;
            o_mem_addr <= i_desc_addr;
         end else if (word_taken) begin
            o_mem_rd   <= (state != SAT_LD_W2);
            o_mem_addr <= o_mem_addr + SAT_DESC_WORD_STEP;
         end
      end
   end

   // Descriptor fields captured word by word
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_limit  <= '0;
         o_base   <= '0;
         o_access <= '0;
      end else if (word_taken) begin
         unique case (state)
            SAT_LD_W0:   o_limit <= i_mem_rdata;
            SAT_LD_W1:   o_base[15:0] <= i_mem_rdata;
            SAT_LD_W2: begin
               o_base[23:16] <= i_mem_rdata[7:0];
               o_access      <= i_mem_rdata[15:8];
            end
            default:     o_limit <= o_limit;
         endcase
      end
   end

endmodule
`default_nettype wire

// File: verilog/sat_top.sv
// Segment address translator: real and protected translation, caches, APB registers
`timescale 1ns/1ps
`default_nettype none
module sat_top
   import sat_pkg::*;
(
   input  wire logic                           i_ref_clk,
   input  wire logic                           i_resetn,
   input  wire logic                           i_psel,
   input  wire logic                           i_penable,
   input  wire logic                           i_pwrite,
   input  wire logic [sat_pkg::SAT_APB_AW-1:0] i_paddr,
   input  wire logic [31:0]                    i_pwdata,
   output logic      [31:0]                    o_prdata,
   output logic                                o_pready,
   output logic                                o_pslverr,
   output logic                                o_irq,
   input  wire logic                           i_seg_load,
   input  wire logic [1:0]                     i_seg_idx,
   input  wire logic [sat_pkg::SAT_SEL_W-1:0]  i_seg_sel,
   input  wire logic                           i_xlat_req,
   input  wire logic [1:0]                     i_xlat_seg,
   input  wire logic [sat_pkg::SAT_OFF_W-1:0]  i_xlat_off,
   input  wire logic                           i_xlat_data,
   output logic                                o_busy,
   output logic                                o_prot_mode,
   output logic                                o_xlat_done,
   output logic                                o_xlat_valid,
   output logic                                o_xlat_fault,
   output logic      [sat_pkg::SAT_PA_W-1:0]   o_xlat_addr,
   output logic                                o_mem_rd,
   output logic      [sat_pkg::SAT_PA_W-1:0]   o_mem_addr,
   input  wire logic                           i_mem_ack,
   input  wire logic [15:0]                    i_mem_rdata
);
   import sat_pkg::*;

   // Selectors and hidden descriptor caches, one slot per register
   logic [SAT_SEL_W-1:0] sel_reg     [SAT_SLOTS];
   logic [SAT_PA_W-1:0]  cache_base  [SAT_SLOTS];
   logic [SAT_OFF_W-1:0] cache_limit [SAT_SLOTS];
   logic [7:0]           cache_acc   [SAT_SLOTS];

   // Global table base register and machine status
   logic [SAT_PA_W-1:0]  global_table_base_reg;
   logic [SAT_OFF_W-1:0] global_table_limit;
   logic                 protection_enable_flag;
   logic                 code_touched;
   logic [SAT_EV_W-1:0]  status;
   logic [SAT_EV_W-1:0]  irq_mask;
   logic [2:0]           load_slot;

   // Loader handshake
   logic                 ld_start;
   logic [SAT_PA_W-1:0]  ld_addr;
   wire                  ld_done;
   wire [SAT_OFF_W-1:0]  ld_limit;
   wire [SAT_PA_W-1:0]   ld_base;
   wire [7:0]            ld_access;

   // APB phase decode; zero wait states, so the access edge is the write edge
   wire apb_setup  = i_psel & ~i_penable;
   wire apb_access = i_psel & i_penable & o_pready;
   wire apb_wr     = apb_access & i_pwrite;
   wire wr_ctrl    = apb_wr && (i_paddr == SAT_REG_CTRL);
   wire wr_status  = apb_wr && (i_paddr == SAT_REG_STATUS);
   wire wr_mask    = apb_wr && (i_paddr == SAT_REG_MASK);
   wire wr_gbase   = apb_wr && (i_paddr == SAT_REG_GBASE);
   wire wr_glimit  = apb_wr && (i_paddr == SAT_REG_GLIMIT);
   wire wr_lsel    = apb_wr && (i_paddr == SAT_REG_LSEL);
   wire addr_hit   = (i_paddr == SAT_REG_CTRL)   || (i_paddr == SAT_REG_STATUS) ||
                     (i_paddr == SAT_REG_MASK)   || (i_paddr == SAT_REG_GBASE)  ||
                     (i_paddr == SAT_REG_GLIMIT) || (i_paddr == SAT_REG_LSEL)   ||
                     (i_paddr == SAT_REG_LBASE)  || (i_paddr == SAT_REG_LLIM)   ||
                     (i_paddr == SAT_REG_LASTPA) || (i_paddr == SAT_REG_STATE);

   // Load request arbitration: execution unit first, local table write second
   wire                 exec_load = i_seg_load & ~o_busy;
   wire                 ltab_load = wr_lsel & ~o_busy & ~i_seg_load;
   wire                 any_load  = exec_load | ltab_load;
   wire [2:0]           new_slot  = exec_load ? {1'b0, i_seg_idx} : SAT_SLOT_LTAB;
   wire [SAT_SEL_W-1:0] new_sel   = exec_load ? i_seg_sel : i_pwdata[SAT_SEL_W-1:0];

   wire                 new_ti  = new_sel[SAT_SEL_TI_BIT] & exec_load;
   wire [SAT_IDX_W-1:0] new_idx = new_sel[SAT_SEL_W-1:SAT_SEL_IDX_LSB];

   // index times eight, added to the chosen table base
   // the local table selector always indexes the global table
   wire [SAT_PA_W-1:0] tab_base  = new_ti ? cache_base[SAT_SLOT_LTAB] : global_table_base_reg;
   wire [SAT_PA_W-1:0] desc_addr = tab_base + {{(SAT_PA_W-SAT_IDX_W-3){1'b0}}, new_idx, SAT_DESC_SHIFT_PAD};

   // a global index above 255 is refused before any memory read
   wire gidx_bad = ~new_ti && (new_idx > SAT_GTAB_MAX_IDX);

   // Real mode loads fill the cache at once; protected loads go to memory
   wire real_fill  = any_load & ~protection_enable_flag;
   wire prot_start = any_load & protection_enable_flag & ~gidx_bad;
   wire gidx_fault = any_load & protection_enable_flag & gidx_bad;

   // real mode segment base is the selector times sixteen
   wire [SAT_PA_W-1:0] real_base = {SAT_NIBBLE_LOW, new_sel, SAT_REAL_SHIFT_PAD};

   // Per-slot selector and cache update
   genvar g;
   generate
      for (g = 0; g < SAT_SLOTS; g++) begin : g_slot
         wire hit_new  = any_load && (new_slot == 3'(g));
         wire hit_fill = ld_done && (load_slot == 3'(g));
         // selector half plus hidden base, limit and access
         always_ff @(posedge i_ref_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               sel_reg[g]     <= (g == 0) ? SAT_CODE_RESET_SEL : '0;
               cache_base[g]  <= (g == 0) ? SAT_CODE_RESET_BASE : '0;
               cache_limit[g] <= SAT_RESET_LIMIT;
               cache_acc[g]   <= SAT_RESET_ACCESS;
            end else begin
               // new selector stored at once unless refused; in protected mode the cache waits for its descriptor
               if (hit_new && !gidx_fault) begin
                  sel_reg[g] <= new_sel;
               end
               if (hit_new && real_fill) begin
                  cache_base[g]  <= real_base;
                  cache_limit[g] <= SAT_RESET_LIMIT;
                  cache_acc[g]   <= SAT_RESET_ACCESS;
               // descriptor copied into the hidden cache
               end else if (hit_fill) begin
                  cache_base[g]  <= ld_base;
                  cache_limit[g] <= ld_limit;
                  cache_acc[g]   <= ld_access;
               end
            end
         end
      end
   endgenerate

   // Busy spans the descriptor fetch; loads during it are ignored
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_busy    <= 1'b0;
         load_slot <= SAT_SLOT_CODE;
         ld_start  <= 1'b0;
         ld_addr   <= '0;
      end else begin
         ld_start <= prot_start;
         if (prot_start) begin
            o_busy    <= 1'b1;
            load_slot <= new_slot;
            ld_addr   <= desc_addr;
         end else if (ld_done) begin
            o_busy <= 1'b0;
         end
      end
   end

   sat_desc_loader u_loader (
      .i_ref_clk   (i_ref_clk),
      .i_resetn    (i_resetn),
      .i_start     (ld_start),
      .i_desc_addr (ld_addr),
      .i_mem_ack   (i_mem_ack),
      .i_mem_rdata (i_mem_rdata),
      .o_mem_rd    (o_mem_rd),
      .o_mem_addr  (o_mem_addr),
      .o_done      (ld_done),
      .o_limit     (ld_limit),
      .o_base      (ld_base),
      .o_access    (ld_access)
   );

   // any code segment load ends the forced-high upper nibble
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         code_touched <= 1'b0;
      end else if (exec_load && (i_seg_idx == SAT_SLOT_CODE[1:0])) begin
         code_touched <= 1'b1;
      end
   end

   // Translation operands from the chosen segment
   wire [SAT_SEL_W-1:0] xs_sel   = sel_reg[{1'b0, i_xlat_seg}];
   wire [SAT_PA_W-1:0]  xs_base  = cache_base[{1'b0, i_xlat_seg}];
   wire [SAT_OFF_W-1:0] xs_limit = cache_limit[{1'b0, i_xlat_seg}];
   wire [7:0]           xs_acc   = cache_acc[{1'b0, i_xlat_seg}];

   wire [SAT_RA_W-1:0] real_sum = {xs_sel, SAT_REAL_SHIFT_PAD} + {SAT_NIBBLE_LOW, i_xlat_off};
   // upper nibble high until the code segment is modified
   // reset code selector with offset FFF0 lands on the reset vector
   wire [3:0]          real_top  = code_touched ? SAT_NIBBLE_LOW : SAT_NIBBLE_HIGH;
   wire [SAT_PA_W-1:0] real_addr = {real_top, real_sum};

   // descriptor base plus offset, no selector shift
   // base, limit and access all come from the cached descriptor
   wire [SAT_PA_W-1:0] prot_addr = xs_base + {{(SAT_PA_W-SAT_OFF_W){1'b0}}, i_xlat_off};

   // requested level from the selector, current level from code selector
   wire [1:0] requested_privilege_level = xs_sel[SAT_SEL_RPL_LSB+1:SAT_SEL_RPL_LSB];
   wire [1:0] current_privilege_level = sel_reg[SAT_SLOT_CODE][SAT_SEL_RPL_LSB+1:SAT_SEL_RPL_LSB];
   wire [1:0] descriptor_privilege_level = xs_acc[SAT_ACC_DPL_LSB+1:SAT_ACC_DPL_LSB];
   // effective level is the numerically larger of the two
   wire [1:0] eff_pl = (requested_privilege_level > current_privilege_level) ? requested_privilege_level : current_privilege_level;

   // a more privileged data segment is a violation, protected mode only
   wire priv_bad  = protection_enable_flag & i_xlat_data & (descriptor_privilege_level < eff_pl);
   wire limit_bad = protection_enable_flag & (i_xlat_off > xs_limit);
   wire xlat_take = i_xlat_req & ~o_busy;
   wire xlat_bad  = priv_bad | limit_bad;

   // Result registered one cycle after the request; a faulting access is suppressed
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_xlat_done  <= 1'b0;
         o_xlat_valid <= 1'b0;
         o_xlat_fault <= 1'b0;
         o_xlat_addr  <= SAT_RESET_VECTOR;
      end else begin
         o_xlat_done  <= xlat_take;
         // no valid address goes out on a fault
         o_xlat_valid <= xlat_take & ~xlat_bad;
         o_xlat_fault <= xlat_take & xlat_bad;
         if (xlat_take && !xlat_bad) begin
            o_xlat_addr <= protection_enable_flag ? prot_addr : real_addr;
         end
      end
   end

   // real mode after reset; the enable flag only sets, it clears at reset
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         protection_enable_flag <= 1'b0;
         o_prot_mode            <= 1'b0;
      end else if (wr_ctrl && i_pwdata[0]) begin
         protection_enable_flag <= 1'b1;
         o_prot_mode            <= 1'b1;   // Pin copy, so the output stays a flop
      end
   end

   // global table base and limit, software loaded
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         global_table_base_reg <= '0;
         global_table_limit    <= '0;
         irq_mask              <= '0;
      end else begin
         if (wr_gbase) global_table_base_reg <= i_pwdata[SAT_PA_W-1:0];
         if (wr_glimit) global_table_limit <= i_pwdata[SAT_OFF_W-1:0];
         if (wr_mask) irq_mask <= i_pwdata[SAT_EV_W-1:0];
      end
   end

   // Sticky events; a new event in the clearing cycle survives the clear
   wire [SAT_EV_W-1:0] ev_set = {ld_done, gidx_fault, xlat_take & limit_bad, xlat_take & priv_bad};
   wire [SAT_EV_W-1:0] ev_clr = wr_status ? i_pwdata[SAT_EV_W-1:0] : '0;

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         status <= '0;
         o_irq  <= 1'b0;
      end else begin
         status <= (status & ~ev_clr) | ev_set;
         o_irq  <= |(((status & ~ev_clr) | ev_set) & irq_mask);
      end
   end

   // Read data selection; unused bits read as zero
   wire [31:0] state_word = {26'h0, code_touched, o_busy,
                             sel_reg[SAT_SLOT_CODE][1:0], 1'b0, protection_enable_flag};
   wire [31:0] rd_mux =
      (i_paddr == SAT_REG_CTRL)   ? {31'h0, protection_enable_flag} :
      (i_paddr == SAT_REG_STATUS) ? {28'h0, status} :
      (i_paddr == SAT_REG_MASK)   ? {28'h0, irq_mask} :
      (i_paddr == SAT_REG_GBASE)  ? {8'h0, global_table_base_reg} :
      (i_paddr == SAT_REG_GLIMIT) ? {16'h0, global_table_limit} :
      (i_paddr == SAT_REG_LSEL)   ? {16'h0, sel_reg[SAT_SLOT_LTAB]} :
      (i_paddr == SAT_REG_LBASE)  ? {8'h0, cache_base[SAT_SLOT_LTAB]} :
      (i_paddr == SAT_REG_LLIM)   ? {8'h0, cache_acc[SAT_SLOT_LTAB], cache_limit[SAT_SLOT_LTAB]} :
      (i_paddr == SAT_REG_LASTPA) ? {8'h0, o_xlat_addr} :
      (i_paddr == SAT_REG_STATE)  ? state_word : 32'h0;

   // Read data and error captured in the setup cycle, ready from reset release on
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_prdata  <= '0;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= 1'b1;
         if (apb_setup) begin
            o_prdata  <= i_pwrite ? 32'h0 : rd_mux;
            o_pslverr <= ~addr_hit;
         end
      end
   end

endmodule
`default_nettype wire

// File: test/sat_top_monitor.sv
// Port-level checker for the segment address translator
`timescale 1ns/1ps
`default_nettype none
module sat_top_monitor
   import sat_pkg::*;
(
   input wire logic i_ref_clk, i_resetn, i_psel, i_penable, i_pwrite, i_seg_load, i_xlat_req,
   input wire logic [SAT_APB_AW-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [1:0] i_seg_idx, i_xlat_seg,
   input wire logic [15:0] i_seg_sel, i_xlat_off,
   input wire logic i_mem_ack, o_busy, o_xlat_done, o_xlat_valid, o_xlat_fault, o_mem_rd,
   input wire logic [23:0] o_xlat_addr, o_mem_addr
);
   logic pe, touched;
   logic [15:0] sel [4];
   wire ld = i_seg_load & ~o_busy;
   wire rq = i_xlat_req & ~o_busy;
   wire [19:0] rsum = {sel[i_xlat_seg], 4'h0} + 20'(i_xlat_off);
   wire [23:0] rpa = {touched ? 4'h0 : 4'hF, rsum};
   // Mode and real-mode selector shadow; protected loads only mark the code touch
   always_ff @(posedge i_ref_clk or negedge i_resetn)
      if (!i_resetn) begin
         pe <= 1'h0;
         touched <= 1'h0;
         sel <= '{SAT_CODE_RESET_SEL, 16'h0, 16'h0, 16'h0};
      end else begin
         if (i_psel & i_penable & i_pwrite & (i_paddr == SAT_REG_CTRL) & i_pwdata[0]) pe <= 1'h1;
         if (ld & (i_seg_idx == 2'h0)) touched <= 1'h1;
         if (ld & ~pe) sel[i_seg_idx] <= i_seg_sel;
      end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   a_done_next: assert property (rq |=> o_xlat_done)
      else $error("no answer after a taken request");
   a_one_outcome: assert property (o_xlat_done |-> o_xlat_valid != o_xlat_fault)
      else $error("answer not exactly one of valid or fault");
   a_real_addr: assert property (rq & ~pe |=> o_xlat_valid && o_xlat_addr == $past(rpa))
      else $error("real mode address wrong");
   a_fetch_held: assert property (o_mem_rd & ~i_mem_ack |=> o_mem_rd && $stable(o_mem_addr))
      else $error("fetch request dropped or moved before ack");
   a_fill_bound: assert property ($rose(o_busy) |-> ##[1:60] !o_busy)
      else $error("descriptor fill never ends");
   a_gidx_refuse: assert property (ld & pe & ~i_seg_sel[2] & (i_seg_sel[15:3] > SAT_GTAB_MAX_IDX)
      |=> !o_busy ##1 !o_mem_rd)
      else $error("global table fetched beyond index limit");
   a_real_quiet: assert property (ld & ~pe |=> !o_busy)
      else $error("real mode load started a fetch");
   a_reset_nibble: assert property (~touched & ~pe |-> o_xlat_addr[23:20] == 4'hF)
      else $error("upper address bits low before code load");
   a_fault_holds: assert property (o_xlat_fault |-> $stable(o_xlat_addr))
      else $error("address changed on a faulted access");
   cover property (o_xlat_fault);
   cover property (o_busy ##1 !o_busy);
   cover property (rq & ~pe ##1 o_xlat_valid);
endmodule
`default_nettype wire

// File: test/sat_desc_mem.sv
// Descriptor memory answering the translator's fetch bus
`timescale 1ns/1ps
`default_nettype none
module sat_desc_mem (
   input wire logic i_ref_clk, i_resetn, i_slow, i_mem_rd,
   input wire logic [23:0] i_mem_addr,
   output logic o_mem_ack,
   output logic [15:0] o_mem_rdata
);
   logic [1:0] wait_cnt;
   wire [12:0] idx = i_mem_addr[15:3];
   // entry n: limit 0FFF, base (n mod 16)*4096, level n mod 4
   wire [15:0] word = (i_mem_addr[2:1] == 2'h0) ? 16'h0FFF :
      (i_mem_addr[2:1] == 2'h1) ? {idx[3:0], 12'h000} : {1'h1, idx[1:0], 5'h12, 8'h00};
   // Idle data toggles so a stale word never passes for a fresh one
   always_ff @(posedge i_ref_clk or negedge i_resetn)
      if (!i_resetn) begin
         o_mem_ack <= 1'h0;
         o_mem_rdata <= 16'h0000;
         wait_cnt <= 2'h0;
      end else if (i_mem_rd & ~o_mem_ack & (~i_slow | (wait_cnt == 2'h3))) begin
         o_mem_ack <= 1'h1;
         o_mem_rdata <= word;
         wait_cnt <= 2'h0;
      end else begin
         o_mem_ack <= 1'h0;
         o_mem_rdata <= ~o_mem_rdata;
         wait_cnt <= i_mem_rd ? wait_cnt + 2'h1 : 2'h0;
      end
endmodule
`default_nettype wire

// File: test/sat_top_test.sv
// Self-checking bench for the segment address translator
`timescale 1ns/1ps
`default_nettype none
module sat_top_test;
   import sat_pkg::*;
   typedef struct packed {logic [1:0] s; logic [15:0] sel, off; logic [23:0] pa;} sat_row_t;
   logic i_ref_clk, i_resetn, i_psel, i_penable, i_pwrite, i_seg_load, i_xlat_req, i_xlat_data, i_slow;
   logic o_pready, o_pslverr, o_irq, o_busy, o_xlat_done, o_xlat_valid, o_xlat_fault, o_mem_rd, i_mem_ack;
   logic err, seen, o_prot_mode;
   logic [7:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic [1:0] i_seg_idx, i_xlat_seg;
   logic [15:0] i_seg_sel, i_xlat_off, i_mem_rdata;
   logic [23:0] o_xlat_addr, o_mem_addr, first_addr;
   int fails = 0, total_checks = 0;
   sat_row_t rows [4] = '{'{2'h1, 16'h1234, 16'h0010, 24'hF12350}, '{2'h0, 16'hFFFF, 16'h0020, 24'h000010},
                          '{2'h1, 16'h1234, 16'h0010, 24'h012350}, '{2'h3, 16'h0000, 16'hFFFF, 24'h00FFFF}};
   sat_top dut (.i_ref_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
      .o_pready, .o_pslverr, .o_irq, .i_seg_load, .i_seg_idx, .i_seg_sel, .i_xlat_req, .i_xlat_seg,
      .i_xlat_off, .i_xlat_data, .o_busy, .o_prot_mode, .o_xlat_done, .o_xlat_valid, .o_xlat_fault,
      .o_xlat_addr, .o_mem_rd, .o_mem_addr, .i_mem_ack, .i_mem_rdata);
   sat_desc_mem mem (.i_ref_clk, .i_resetn, .i_slow, .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
      .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));
   initial begin
      i_ref_clk = 1'h0;
      forever #2 i_ref_clk = ~i_ref_clk;
   end
   // First fetch address of each descriptor load
   always @(posedge i_ref_clk) if (o_mem_rd && !seen) begin first_addr = o_mem_addr; seen = 1'h1; end
   task automatic chk(input string what, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin fails++; $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge i_ref_clk);
      i_psel <= 1'h1; i_penable <= 1'h0; i_pwrite <= wr; i_paddr <= a; i_pwdata <= wd;
      @(posedge i_ref_clk) i_penable <= 1'h1;
      do @(posedge i_ref_clk); while (o_pready !== 1'h1);
      rd = o_prdata; err = o_pslverr;
      i_psel <= 1'h0; i_penable <= 1'h0;
   endtask
   task automatic fill;
      repeat (3) @(negedge i_ref_clk);
      while (o_busy !== 1'h0) @(negedge i_ref_clk);
   endtask
   task automatic seg(input logic [1:0] s, input logic [15:0] v);
      @(posedge i_ref_clk);
      i_seg_load <= 1'h1; i_seg_idx <= s; i_seg_sel <= v; seen = 1'h0;
      @(posedge i_ref_clk) i_seg_load <= 1'h0;
      fill();
   endtask
   task automatic xl(input logic [1:0] s, input logic [15:0] off, input logic dat, f, input logic [23:0] pa);
      @(posedge i_ref_clk);
      i_xlat_req <= 1'h1; i_xlat_seg <= s; i_xlat_off <= off; i_xlat_data <= dat;
      @(posedge i_ref_clk) i_xlat_req <= 1'h0;
      @(negedge i_ref_clk);
      chk("fault", f, o_xlat_fault);
      chk("valid", !f, o_xlat_valid);
      if (!f) chk("addr", pa, o_xlat_addr);
   endtask
   task automatic tally_and_finish;
      if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin #20000; fails++; tally_and_finish(); end
   initial begin
      {i_psel, i_penable, i_pwrite, i_seg_load, i_xlat_req, i_xlat_data, i_slow, i_resetn, seen} = '0;
      i_paddr = 8'h00; i_pwdata = 32'h0; i_seg_idx = 2'h0; i_seg_sel = 16'h0; i_xlat_seg = 2'h0; i_xlat_off = 16'h0;
      repeat (8) @(posedge i_ref_clk);
      i_resetn <= 1'h1;
      chk("reset addr", SAT_RESET_VECTOR, o_xlat_addr);
      chk("real pin", 1'h0, o_prot_mode);
      xl(2'h0, 16'hFFF0, 1'h0, 1'h0, SAT_RESET_VECTOR);
      foreach (rows[i]) begin
         seg(rows[i].s, rows[i].sel);
         xl(rows[i].s, rows[i].off, 1'h1, 1'h0, rows[i].pa);
      end
      apb(1'h1, SAT_REG_MASK, 32'h4);
      apb(1'h1, SAT_REG_GBASE, 32'h010000);
      apb(1'h1, SAT_REG_GLIMIT, 32'hFFFF);
      apb(1'h1, SAT_REG_CTRL, 32'h1);
      apb(1'h0, SAT_REG_STATE, 32'h0); chk("mode", 1'h1, rd[0]);
      chk("mode pin", 1'h1, o_prot_mode);
      seg(2'h0, 16'h000B); chk("desc addr", 24'h010008, first_addr);
      i_slow <= 1'h1;
      seg(2'h1, 16'h0018); chk("desc addr", 24'h010018, first_addr);
      i_slow <= 1'h0;
      xl(2'h1, 16'h0123, 1'h1, 1'h0, 24'h003123);
      xl(2'h1, 16'h1000, 1'h1, 1'h1, 24'h0);
      seg(2'h2, 16'h0010);
      xl(2'h2, 16'h0010, 1'h1, 1'h1, 24'h0);
      xl(2'h2, 16'h0010, 1'h0, 1'h0, 24'h002010);
      seg(2'h1, 16'h0800); @(negedge i_ref_clk);
      chk("irq", 1'h1, o_irq);
      xl(2'h1, 16'h0123, 1'h1, 1'h0, 24'h003123);
      apb(1'h1, SAT_REG_MASK, 32'h0); repeat (2) @(negedge i_ref_clk);
      chk("irq masked", 1'h0, o_irq);
      apb(1'h0, SAT_REG_STATUS, 32'h0); chk("gidx", 1'h1, rd[2]);
      apb(1'h1, SAT_REG_STATUS, 32'h4);
      apb(1'h0, SAT_REG_STATUS, 32'h0); chk("gidx clr", 1'h0, rd[2]);
      seen = 1'h0; apb(1'h1, SAT_REG_LSEL, 32'h0010); fill();
      chk("ldesc addr", 24'h010010, first_addr);
      apb(1'h0, SAT_REG_LBASE, 32'h0); chk("lbase", 32'h002000, rd);
      seg(2'h3, 16'h000C); chk("ltab addr", 24'h002008, first_addr);
      xl(2'h3, 16'h0004, 1'h0, 1'h0, 24'h001004);
      // Level zero code: only the selector's requested level can make the access fault
      seg(2'h0, 16'h0008);
      seg(2'h2, 16'h0013);
      xl(2'h2, 16'h0010, 1'h1, 1'h1, 24'h0);
      seg(2'h2, 16'h0010);
      xl(2'h2, 16'h0010, 1'h1, 1'h0, 24'h002010);
      apb(1'h0, 8'h40, 32'h0); chk("slverr", 1'h1, err);
      tally_and_finish();
   end
endmodule
bind sat_top sat_top_monitor mon (.i_ref_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_seg_load,
   .i_xlat_req, .i_paddr, .i_pwdata, .i_seg_idx, .i_xlat_seg, .i_seg_sel, .i_xlat_off, .i_mem_ack,
   .o_busy, .o_xlat_done, .o_xlat_valid, .o_xlat_fault, .o_mem_rd, .o_xlat_addr, .o_mem_addr);
`default_nettype wire
